// ==== design/osld_map.svh ====
// Constants for the octal serial load driver control block.
// Assumes a 200 MHz system clock and a host-driven serial link clock.
// Summary of operation
// - Active-low asynchronous reset clears the shift register, sets the latch to all ones and turns the output stages off at once.
// - Select rising edge copies the eight shift bits into the parallel latch.
// - Select falling edge loads the shift register with the eight sense bits.
// - Serial output floats while select is high, driven while select is low.
// - Diagnostic bit reads one for a pin sensed high, zero when low.
// - Control bit one programs the output off, zero programs it on.
// - Output next bit after each rising serial clock, sample input on falling.
// - Most significant first; output seven first, output zero last.
// - An on output sensed high is a fault; its fault mask bit is set, forcing it off.
// - Fault clearing acts only after 65 to 260 us from select rising.
// - An off output with open pin senses low, so reads zero.
// - Device is selected for transfers only while select is low.
// - Latch holds its byte until rewritten or reset; faults mask it per bit without changing it.
// - An on output drives its pin low; an off output releases it.
// - Each select rising edge starts a 135 us delay inhibiting fault clearing.
// - Serial clock is ignored whenever select is high.
`ifndef OSLD_MAP_SVH
`define OSLD_MAP_SVH

`define OSLD_WIDTH 8
`define OSLD_MSB 7
`define OSLD_LATCH_RST 8'hFF
`define OSLD_SHIFT_RST 8'h00
`define OSLD_CLK_MHZ 200
`define OSLD_DELAY_US 135
`define OSLD_DELAY_CYC (`OSLD_DELAY_US * `OSLD_CLK_MHZ)
`define OSLD_CNT_W 15

`endif

// ==== design/osld_pkg.sv ====
// Types for the octal serial load driver control block.
// Assumes the constant header is on the include path.
`default_nettype none
`include "osld_map.svh"

package osld_pkg;
    typedef logic [`OSLD_MSB:0] osld_byte_t;
    typedef enum logic [0:0] {
        OSLD_ARMED = 1'b0,
        OSLD_WAIT = 1'b1
    } osld_state_t;
endpackage

`default_nettype wire

// ==== design/osld_sync.sv ====
// Two-flop level synchroniser into the system clock domain.
// Assumes the input is asynchronous to clk.
`default_nettype none

module osld_sync
    import osld_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Data
    input wire logic d,
    output logic q
);
    logic meta_r;
    logic meta_nxt;
    logic q_r;
    logic q_nxt;

    always_comb begin
        meta_nxt = d;
        q_nxt = meta_r;
    end

    // Only the second flop is read outside
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r <= 1'b0;
            q_r <= 1'b0;
        end else begin
            meta_r <= meta_nxt;
            q_r <= q_nxt;
        end
    end

    assign q = q_r;
endmodule // osld_sync

`default_nettype wire

// ==== design/osld_shift.sv ====
// Serial shift register clocked by the link clock.
// Assumes sense bits are stable around the select falling edge.
`default_nettype none
`include "osld_map.svh"

module osld_shift
    import osld_pkg::*;
(
    // Link clock and async reset
    input wire logic sclk,
    input wire logic reset_n,
    // Link pins
    input wire logic cs_n,
    input wire logic si,
    // Jam pending: no falling sclk yet since select fell
    input wire logic load,
    input wire osld_byte_t sense,
    // State
    output osld_byte_t shift,
    output logic so_bit
);
    osld_byte_t cap_r;
    osld_byte_t shift_r;
    osld_byte_t shift_nxt;
    osld_byte_t src;
    logic so_r;

    // Until the first falling sclk the captured sense byte is the register
    assign src = load ? cap_r : shift_r;

    // Shift at falling edge: serial in at bit 0, msb leaves first
    always_comb begin
        shift_nxt = shift_r;
        if (!cs_n) begin
            shift_nxt = {src[`OSLD_MSB-1:0], si};
        end
    end

    // Captured on the select edge itself, so no sclk edge is needed
    always_ff @(negedge cs_n or negedge reset_n) begin
        if (!reset_n) begin
            cap_r <= `OSLD_SHIFT_RST;
        end else begin
            cap_r <= sense;
        end
    end

    always_ff @(negedge sclk or negedge reset_n) begin
        if (!reset_n) begin
            shift_r <= `OSLD_SHIFT_RST;
        end else begin
            shift_r <= shift_nxt;
        end
    end

    // Serial out updates on every rising edge while select is low
    always_ff @(posedge sclk or negedge reset_n) begin
        if (!reset_n) begin
            so_r <= 1'b0;
        end else if (!cs_n) begin
            so_r <= src[`OSLD_MSB];
        end
    end

    assign shift = src;
    assign so_bit = so_r;
endmodule // osld_shift

`default_nettype wire

// ==== design/osld_ctrl.sv ====
// Top of the octal serial load driver control logic.
// Assumes a host serial master on the link pins and comparators on sense.
`default_nettype none
`include "osld_map.svh"

module osld_ctrl
    import osld_pkg::*;
(
    // System clock and reset
    input wire logic clk,
    input wire logic rst,
    // Device reset pin, active low, asynchronous
    input wire logic reset_n,
    // Serial link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic si,
    output logic so_o,
    output logic so_oe,
    // Output stages: comparator sense and low-side drive
    input wire osld_byte_t sense,
    output osld_byte_t out_o,
    output osld_byte_t out_oe
);
    // ----------------------------------------------------------------
    // Select edges
    // ----------------------------------------------------------------
    osld_byte_t shift;
    logic so_bit;
    logic sel_sync;
    logic sel_d_r;
    logic sel_d_nxt;
    logic cs_rise;

    // Jam stays pending until the first falling sclk of a frame
    logic jam_pend_r;
    always_ff @(negedge sclk or negedge reset_n or posedge cs_n) begin
        if (!reset_n) begin
            jam_pend_r <= 1'b1;
        end else if (cs_n) begin
            jam_pend_r <= 1'b1;
        end else begin
            jam_pend_r <= 1'b0;
        end
    end
    // Set by the first rising sclk of a frame
    logic jam_hold_r;
    always_ff @(posedge sclk or negedge reset_n or posedge cs_n) begin
        if (!reset_n) begin
            jam_hold_r <= 1'b0;
        end else if (cs_n) begin
            jam_hold_r <= 1'b0;
        end else begin
            jam_hold_r <= 1'b1;
        end
    end
    osld_shift u_shift (
        .sclk(sclk),
        .reset_n(reset_n),
        .cs_n(cs_n),
        .si(si),
        .load(jam_pend_r),
        .sense(sense),
        .shift(shift),
        .so_bit(so_bit)
    );

    // Before the first rising sclk the msb itself is shown
    assign so_o = jam_hold_r ? so_bit : shift[`OSLD_MSB];
    assign so_oe = ~cs_n;

    // ----------------------------------------------------------------
    // Parallel latch
    // ----------------------------------------------------------------
    osld_byte_t latch_r;
    always_ff @(posedge cs_n or negedge reset_n) begin
        if (!reset_n) begin
            latch_r <= `OSLD_LATCH_RST;
        end else begin
            latch_r <= shift;
        end
    end

    // Sync carries select active, so its reset level is the idle level
    osld_sync u_cs_sync (
        .clk(clk),
        .rst(rst),
        .d(~cs_n),
        .q(sel_sync)
    );
    always_comb begin
        sel_d_nxt = sel_sync;
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            sel_d_r <= 1'b0;
        end else begin
            sel_d_r <= sel_d_nxt;
        end
    end
    assign cs_rise = ~sel_sync & sel_d_r;

    // ----------------------------------------------------------------
    // Fault clear delay and fault mask
    // ----------------------------------------------------------------
    osld_state_t state_r;
    osld_state_t state_nxt;
    logic [`OSLD_CNT_W-1:0] fault_clear_delay_r;
    logic [`OSLD_CNT_W-1:0] fault_clear_delay_nxt;
    osld_byte_t fault_r;
    osld_byte_t fault_nxt;
    osld_byte_t sense_s1_r;
    osld_byte_t sense_s2_r;
    logic rst_s1_r;
    logic rst_s2_r;
    // Latch copy for the compare, taken once the select rise is synced
    osld_byte_t latch_s_r;
    osld_byte_t latch_s_nxt;

    // Sense and reset pin are asynchronous to clk
    always_ff @(posedge clk) begin
        if (rst) begin
            sense_s1_r <= `OSLD_SHIFT_RST;
            sense_s2_r <= `OSLD_SHIFT_RST;
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            sense_s1_r <= sense;
            sense_s2_r <= sense_s1_r;
            rst_s1_r <= reset_n;
            rst_s2_r <= rst_s1_r;
        end
    end

    always_comb begin
        state_nxt = state_r;
        fault_clear_delay_nxt = fault_clear_delay_r;
        fault_nxt = fault_r;
        latch_s_nxt = latch_s_r;
        if (cs_rise) begin
            // New byte written: earlier fault clears are dropped
            state_nxt = OSLD_WAIT;
            fault_clear_delay_nxt = `OSLD_CNT_W'(`OSLD_DELAY_CYC - 1);
            fault_nxt = `OSLD_SHIFT_RST;
            // Latch has been settled since select rose two clocks back
            latch_s_nxt = latch_r;
        end else begin
            unique case (state_r)
                OSLD_WAIT: begin
                    if (fault_clear_delay_r == '0) begin
                        state_nxt = OSLD_ARMED;
                    end else begin
                        fault_clear_delay_nxt = fault_clear_delay_r - 1'b1;
                    end
                end
                OSLD_ARMED: begin
                    // On output still sensed high is a fault, sticky
                    fault_nxt = fault_r | (sense_s2_r & ~latch_s_r);
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst || !rst_s2_r) begin
            state_r <= OSLD_ARMED;
            fault_clear_delay_r <= '0;
            fault_r <= `OSLD_SHIFT_RST;
            latch_s_r <= `OSLD_LATCH_RST;
        end else begin
            state_r <= state_nxt;
            fault_clear_delay_r <= fault_clear_delay_nxt;
            fault_r <= fault_nxt;
            latch_s_r <= latch_s_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Output stages
    // ----------------------------------------------------------------
    // Latch bit one or fault means off; off releases the pin
    assign out_o = `OSLD_SHIFT_RST;
    assign out_oe = reset_n ? ~(latch_r | fault_r) : `OSLD_SHIFT_RST;
endmodule // osld_ctrl

`default_nettype wire

// ==== tb/osld_ctrl_chk.sv ====
// Checker bound to the load driver control top.
// Assumes clk at 200 MHz; sense is driven from out_oe by the bench pin model.
`default_nettype none
module osld_ctrl_chk
    import osld_pkg::*;
(
    // Clocks and resets
    input wire logic clk,
    input wire logic rst,
    input wire logic reset_n,
    // Link and pins
    input wire logic cs_n,
    input wire logic so_o,
    input wire logic so_oe,
    input wire osld_byte_t sense,
    input wire osld_byte_t out_o,
    input wire osld_byte_t out_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    // --------------------------------
    // Cycles since select rose
    // --------------------------------
    localparam int HOLD = 13000;
    localparam int LATE = 52000;
    logic [15:0] gap_r;
    logic [15:0] gap_nxt;
    logic cs_r;
    logic cs_nxt;
    always_comb begin
        cs_nxt = cs_n;
        gap_nxt = (gap_r == 16'hFFFF) ? gap_r : gap_r + 16'h0001;
        if (cs_n && !cs_r) begin
            gap_nxt = 16'h0000;
        end
    end
    always_ff @(posedge clk) begin
        cs_r <= rst ? 1'b1 : cs_nxt;
        gap_r <= rst ? 16'h0000 : gap_nxt;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst || !reset_n);
    so_enable_a: assert property (so_oe == !cs_n) else $error("so enable wrong");
    low_drive_a: assert property (out_o == 8'h00) else $error("out not low");
    reset_off_a: assert property (@(posedge clk) disable iff (rst)
        !reset_n |-> out_oe == 8'h00) else $error("reset left outputs on");
    first_bit_a: assert property ($fell(cs_n) |-> so_o == sense[7])
        else $error("first diag bit wrong");
    latch_new_a: assert property ((out_oe & ~$past(out_oe)) != 8'h00 |-> $rose(cs_n))
        else $error("output on without select rise");
    fault_hold_a: assert property (gap_r < HOLD && !$rose(cs_n) |-> $stable(out_oe))
        else $error("fault clear too early");
    fault_late_a: assert property (cs_n && gap_r == LATE |-> (out_oe & sense) == 8'h00)
        else $error("fault not cleared");
    fault_why_a: assert property (!$rose(cs_n) |->
        ($past(out_oe) & ~out_oe & ~$past(sense)) == 8'h00) else $error("clear without fault");
    cover property ($rose(cs_n));
    cover property ($fell(cs_n) && so_o);
    cover property (cs_n && gap_r == LATE && out_oe != 8'hFF);
endmodule // osld_ctrl_chk
bind osld_ctrl osld_ctrl_chk chk (.clk, .rst, .reset_n, .cs_n, .so_o, .so_oe, .sense, .out_o,
    .out_oe);
`default_nettype wire

// ==== tb/osld_host.sv ====
// Host serial master model, sixteen bits per frame (two chained bytes).
// Assumes so is resolved to a level by the bench.
`default_nettype none
module osld_host (
    // Link
    output logic sclk,
    output logic cs_n,
    output logic si,
    input wire logic so,
    // Result
    output logic [15:0] rx,
    output logic done
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        {sclk, cs_n, si, done} = 4'h4;
        rx = 16'h0000;
    end
    // Odd offset keeps select edges off clk edges
    task automatic xfer(input logic [15:0] tx);
        #1.3 cs_n <= 1'b0;
        // Data moves mid low phase; so is taken mid high phase
        for (int i = 15; i >= 0; i--) begin
            #4 si <= tx[i];
            #3.5 sclk <= 1'b1;
            #4 rx[i] = so;
            #3.5 sclk <= 1'b0;
        end
        #7.5 cs_n <= 1'b1;
        si <= ~si;
        #3 done <= ~done;
    endtask
endmodule // osld_host
`default_nettype wire

// ==== tb/osld_ctrl_tb.sv ====
// Self-checking bench for the load driver control top.
// Assumes the host model drives the link; the bench models the pins.
`default_nettype none
module osld_ctrl_tb;
    import osld_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rst, reset_n, so_o, so_oe, so_w, sclk, cs_n, si, done;
    logic so_tgl = 1'b0;
    osld_byte_t sense, out_o, out_oe, latch_m, load_m, short_m;
    logic [15:0] rx;
    logic [23:0] exp_q[$];
    int n_fail = 0;
    int num_checks = 0;
    int seed = 35;
    osld_ctrl dut (.clk(clk), .rst(rst), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n), .si(si),
        .so_o(so_o), .so_oe(so_oe), .sense(sense), .out_o(out_o), .out_oe(out_oe));
    osld_host host (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so_w), .rx(rx), .done(done));
    // Released so shows a changing pattern, never the last bit
    assign so_w = so_oe ? so_o : so_tgl;
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // --------------------------------
    // Pins: shorted on, loaded off read high
    // --------------------------------
    always @(posedge clk) begin
        so_tgl <= ~so_tgl;
        sense <= (~out_oe & load_m) | (out_oe & short_m);
    end
    task automatic check(input logic [23:0] got, input logic [23:0] want);
        num_checks++;
        if (got !== want) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, want);
        end
    endtask
    always @(done) begin
        if (exp_q.size() > 0) begin
            check({rx, out_oe}, exp_q.pop_front());
        end
    end
    task automatic frame(input logic [15:0] tx);
        exp_q.push_back({(~latch_m & short_m) | (latch_m & load_m), tx[15:8], ~tx[7:0]});
        latch_m = tx[7:0];
        host.xfer(tx);
        @(posedge clk);
    endtask
    task automatic wrap_up;
        if (exp_q.size() != 0) begin
            n_fail++;
        end
        $display("checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        #400000;
        n_fail++;
        wrap_up();
    end
    initial begin
        {rst, reset_n, latch_m, load_m, short_m, sense} = {2'b10, 8'hFF, 24'h000000};
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        check({16'h0000, out_oe}, 24'h000000);
        for (int k = 0; k < 8; k++) begin
            frame($random(seed));
            load_m <= $random(seed);
        end
        $display("test random frames done");
        short_m = 8'h0F;
        @(posedge clk);
        frame(16'h5A00);
        repeat (53000) @(posedge clk);
        latch_m = latch_m | short_m;
        check({16'h0000, out_oe}, {16'h0000, ~latch_m});
        frame(16'hA5FF);
        $display("test fault done");
        frame(16'h3C81);
        reset_n <= 1'b0;
        @(posedge clk);
        check({16'h0000, out_oe}, 24'h000000);
        latch_m = 8'hFF;
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        frame(16'hC3F0);
        $display("test mid reset done");
        wrap_up();
    end
endmodule // osld_ctrl_tb
`default_nettype wire
